// >>> common/framer_dma_pkg.sv
// Constants and carrier types for the framer receive DMA and interrupt control block
package framer_dma_pkg;

    // ====================================================================
    // Register map
    localparam logic [15:0] DMA_CFG_ADDR = 16'h0119;
    localparam logic [15:0] IRQ_CTRL_ADDR = 16'h011A;
    localparam logic [15:0] IRQ_STATUS_ADDR = 16'h011B;
    localparam logic [15:0] IRQ_ENABLE_ADDR = 16'h011C;

    // ====================================================================
    // Field positions
    localparam int DMA_RESET_BIT = 7;
    localparam int DMA_ENABLE_BIT = 6;
    localparam int STROBE_STYLE_BIT = 5;
    localparam int CHAN_SEL_LSB = 0;
    localparam int CHAN_SEL_MSB = 2;
    localparam int CLEAR_POLICY_BIT = 2;
    localparam int AUTOCLEAR_BIT = 1;
    localparam int IRQ_ENABLE_BIT = 0;

    // ====================================================================
    // Widths and reset values
    localparam int IRQ_SOURCES = 8;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] CHAN_RESERVED_MASK = 3'h4;

    // ====================================================================
    // Carrier types
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [15:0] addr;
        logic [7:0] wdata;
    } upbus_t;

    typedef struct packed {
        logic read_dma_reset;
        logic read_dma_enable;
        logic strobe_style;
        logic [2:0] read_dma_channel_select;
    } dma_cfg_t;

    typedef struct packed {
        logic status_clear_policy;
        logic enable_autoclear;
        logic framer_irq_enable;
    } irq_ctrl_t;

    typedef enum logic [1:0] {DMA_IDLE, DMA_ACTIVE, DMA_DRAIN} dma_state_t;

    typedef struct packed {
        upbus_t bus_meta;
        upbus_t bus_sync;
        upbus_t bus_prev;
        logic grant_meta;
        logic grant_sync;
        dma_cfg_t dma_cfg;
        irq_ctrl_t irq_ctrl;
        dma_state_t dma_state;
        logic req_n;
        logic [7:0] dout;
        logic oe_n;
        logic pop;
        logic flush;
    } ctrl_state_t;

    typedef struct packed {
        logic [IRQ_SOURCES-1:0] status;
        logic [IRQ_SOURCES-1:0] enable;
        logic irq;
    } irq_state_t;

    localparam upbus_t BUS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 16'h0000, wdata: 8'h00};

    localparam ctrl_state_t CTRL_RESET = '{
        bus_meta: BUS_IDLE,
        bus_sync: BUS_IDLE,
        bus_prev: BUS_IDLE,
        grant_meta: 1'b1,
        grant_sync: 1'b1,
        dma_cfg: '0,
        irq_ctrl: '0,
        dma_state: DMA_IDLE,
        req_n: 1'b1,
        dout: 8'h00,
        oe_n: 1'b1,
        pop: 1'b0,
        flush: 1'b0
    };

    localparam irq_state_t IRQ_RESET = '{status: '0, enable: '0, irq: 1'b0};

endpackage

// >>> hdl/irq_policy.sv
// Interrupt status, enable and clearing policy for the framer block
`timescale 1ns/1ns
`default_nettype none

module irq_policy
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Policy controls
    input wire framer_dma_pkg::irq_ctrl_t ctrl,
    // Framer events
    input wire logic [framer_dma_pkg::IRQ_SOURCES-1:0] events,
    // Register access pulses
    input wire logic status_read,
    input wire logic status_write,
    input wire logic enable_write,
    input wire logic [framer_dma_pkg::IRQ_SOURCES-1:0] wdata,
    // State out
    output logic [framer_dma_pkg::IRQ_SOURCES-1:0] status,
    output logic [framer_dma_pkg::IRQ_SOURCES-1:0] enable,
    output logic irq
);

    framer_dma_pkg::irq_state_t st;
    framer_dma_pkg::irq_state_t next_st;

    // ====================================================================
    // Next state
    always_comb
    begin
        logic [framer_dma_pkg::IRQ_SOURCES-1:0] clr;
        clr = '0;
        next_st = st;
        if (status_read && !ctrl.status_clear_policy)
        begin
            clr = st.status;
        end
        else if (status_write && ctrl.status_clear_policy)
        begin
            clr = wdata;
        end
        // New events win over a clear in the same cycle
        next_st.status = (st.status & ~clr) | events;
        if (enable_write)
        begin
            next_st.enable = wdata;
        end
        else if (status_read && ctrl.enable_autoclear)
        begin
            next_st.enable = st.enable & ~st.status;
        end
        // Without auto-clear a status read leaves the enables unchanged
        next_st.irq = ctrl.framer_irq_enable & (|(st.status & st.enable));
    end

    // ====================================================================
    // State register
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            st <= framer_dma_pkg::IRQ_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign status = st.status;
    assign enable = st.enable;
    assign irq = st.irq;

endmodule

`default_nettype wire

// >>> hdl/framer_rx_dma_and_irq_control.sv
// Receive DMA read interface, microprocessor registers and interrupt policy of one framer channel
`timescale 1ns/1ns
`default_nettype none

module framer_rx_dma_and_irq_control
#(
    parameter logic [2:0] CHANNEL_ID = 3'h0
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Microprocessor bus pins
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [15:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    // DMA handshake pins
    output logic read_transfer_request_n,
    input wire logic read_transfer_grant_n,
    // Receive HDLC buffer
    input wire logic msg_ready,
    input wire logic [7:0] buf_data,
    input wire logic buf_last,
    output logic buf_pop,
    output logic buf_flush,
    // Interrupts
    input wire logic [framer_dma_pkg::IRQ_SOURCES-1:0] irq_events,
    output logic framer_irq
);

    framer_dma_pkg::ctrl_state_t st;
    framer_dma_pkg::ctrl_state_t next_st;
    framer_dma_pkg::upbus_t bus_pins;

    logic status_read;
    logic status_write;
    logic enable_write;
    logic [framer_dma_pkg::IRQ_SOURCES-1:0] irq_status;
    logic [framer_dma_pkg::IRQ_SOURCES-1:0] irq_enable;

    assign bus_pins = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, addr: addr, wdata: data_in};

    // ====================================================================
    // Interrupt policy
    irq_policy irq_unit
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ctrl(st.irq_ctrl),
        .events(irq_events),
        .status_read(status_read),
        .status_write(status_write),
        .enable_write(enable_write),
        .wdata(st.bus_sync.wdata),
        .status(irq_status),
        .enable(irq_enable),
        .irq(framer_irq)
    );

    // ====================================================================
    // Next state
    always_comb
    begin
        logic rd_fall;
        logic rd_rise;
        logic wr_fall;
        logic wr_rise;
        logic read_start;
        logic write_start;
        logic read_end;
        logic dma_phase;
        logic reg_sel;
        logic chan_match;
        logic run;
        logic dma_reset;
        logic [7:0] rdata;
        logic [7:0] wd;
        rd_fall = 1'b0;
        rd_rise = 1'b0;
        wr_fall = 1'b0;
        wr_rise = 1'b0;
        read_start = 1'b0;
        write_start = 1'b0;
        read_end = 1'b0;
        dma_phase = 1'b0;
        reg_sel = 1'b0;
        chan_match = 1'b0;
        run = 1'b0;
        dma_reset = 1'b0;
        rdata = framer_dma_pkg::REG_RESET;
        wd = st.bus_sync.wdata;
        status_read = 1'b0;
        status_write = 1'b0;
        enable_write = 1'b0;
        next_st = st;

        // Pin synchronisers and edge history
        next_st.bus_meta = bus_pins;
        next_st.bus_sync = st.bus_meta;
        next_st.bus_prev = st.bus_sync;
        next_st.grant_meta = read_transfer_grant_n;
        next_st.grant_sync = st.grant_meta;
        next_st.pop = 1'b0;
        next_st.flush = 1'b0;

        rd_fall = st.bus_prev.rd_n & ~st.bus_sync.rd_n;
        rd_rise = ~st.bus_prev.rd_n & st.bus_sync.rd_n;
        wr_fall = st.bus_prev.wr_n & ~st.bus_sync.wr_n;
        wr_rise = ~st.bus_prev.wr_n & st.bus_sync.wr_n;

        // Strobe style decode
        if (st.dma_cfg.strobe_style)
        begin
            read_start = wr_fall & ~st.bus_sync.rd_n;
            write_start = wr_fall & st.bus_sync.rd_n;
            read_end = wr_rise;
        end
        else
        begin
            read_start = rd_fall;
            write_start = wr_fall;
            read_end = rd_rise;
        end

        dma_phase = ~st.grant_sync && (st.dma_state != framer_dma_pkg::DMA_IDLE);
        reg_sel = ~st.bus_sync.cs_n & ~dma_phase;

        // Channel match, reserved codes never match
        chan_match = (st.dma_cfg.read_dma_channel_select == CHANNEL_ID) &&
                     ((st.dma_cfg.read_dma_channel_select & framer_dma_pkg::CHAN_RESERVED_MASK) == 3'h0);
        run = st.dma_cfg.read_dma_enable & chan_match;

        // Register read mux, reserved bits zero
        unique case (st.bus_sync.addr)
            framer_dma_pkg::DMA_CFG_ADDR:
            begin
                rdata[framer_dma_pkg::DMA_RESET_BIT] = st.dma_cfg.read_dma_reset;
                rdata[framer_dma_pkg::DMA_ENABLE_BIT] = st.dma_cfg.read_dma_enable;
                rdata[framer_dma_pkg::STROBE_STYLE_BIT] = st.dma_cfg.strobe_style;
                rdata[framer_dma_pkg::CHAN_SEL_MSB:framer_dma_pkg::CHAN_SEL_LSB] =
                    st.dma_cfg.read_dma_channel_select;
            end
            framer_dma_pkg::IRQ_CTRL_ADDR:
            begin
                rdata[framer_dma_pkg::CLEAR_POLICY_BIT] = st.irq_ctrl.status_clear_policy;
                rdata[framer_dma_pkg::AUTOCLEAR_BIT] = st.irq_ctrl.enable_autoclear;
                rdata[framer_dma_pkg::IRQ_ENABLE_BIT] = st.irq_ctrl.framer_irq_enable;
            end
            framer_dma_pkg::IRQ_STATUS_ADDR:
            begin
                rdata = irq_status;
            end
            framer_dma_pkg::IRQ_ENABLE_ADDR:
            begin
                rdata = irq_enable;
            end
            default:
            begin
                rdata = framer_dma_pkg::REG_RESET;
            end
        endcase

        // Register read: drive the bus until the strobe returns high
        if (reg_sel && read_start)
        begin
            next_st.dout = rdata;
            next_st.oe_n = 1'b0;
            status_read = (st.bus_sync.addr == framer_dma_pkg::IRQ_STATUS_ADDR);
        end
        if (read_end)
        begin
            next_st.oe_n = 1'b1;
        end

        // Register write
        if (reg_sel && write_start)
        begin
            unique case (st.bus_sync.addr)
                framer_dma_pkg::DMA_CFG_ADDR:
                begin
                    next_st.dma_cfg.read_dma_reset = wd[framer_dma_pkg::DMA_RESET_BIT];
                    next_st.dma_cfg.read_dma_enable = wd[framer_dma_pkg::DMA_ENABLE_BIT];
                    next_st.dma_cfg.strobe_style = wd[framer_dma_pkg::STROBE_STYLE_BIT];
                    next_st.dma_cfg.read_dma_channel_select =
                        wd[framer_dma_pkg::CHAN_SEL_MSB:framer_dma_pkg::CHAN_SEL_LSB];
                    dma_reset = ~st.dma_cfg.read_dma_reset & wd[framer_dma_pkg::DMA_RESET_BIT];
                end
                framer_dma_pkg::IRQ_CTRL_ADDR:
                begin
                    next_st.irq_ctrl.status_clear_policy = wd[framer_dma_pkg::CLEAR_POLICY_BIT];
                    next_st.irq_ctrl.enable_autoclear = wd[framer_dma_pkg::AUTOCLEAR_BIT];
                    next_st.irq_ctrl.framer_irq_enable = wd[framer_dma_pkg::IRQ_ENABLE_BIT];
                end
                framer_dma_pkg::IRQ_STATUS_ADDR:
                begin
                    status_write = 1'b1;
                end
                framer_dma_pkg::IRQ_ENABLE_ADDR:
                begin
                    enable_write = 1'b1;
                end
                default:
                begin
                    next_st.dma_cfg = st.dma_cfg;
                end
            endcase
        end

        // ================================================================
        // DMA read sequencer
        unique case (st.dma_state)
            framer_dma_pkg::DMA_IDLE:
            begin
                if (run && msg_ready)
                begin
                    next_st.dma_state = framer_dma_pkg::DMA_ACTIVE;
                    next_st.req_n = 1'b0;
                end
            end
            framer_dma_pkg::DMA_ACTIVE:
            begin
                // Bytes move only while the controller grants
                if (dma_phase && read_start)
                begin
                    next_st.dout = buf_data;
                    next_st.oe_n = 1'b0;
                    next_st.pop = 1'b1;
                    if (buf_last)
                    begin
                        next_st.dma_state = framer_dma_pkg::DMA_DRAIN;
                        next_st.req_n = 1'b1;
                    end
                end
            end
            framer_dma_pkg::DMA_DRAIN:
            begin
                // Wait for the last strobe or the grant to go away
                if (read_end || st.grant_sync)
                begin
                    next_st.dma_state = framer_dma_pkg::DMA_IDLE;
                end
            end
            default:
            begin
                next_st.dma_state = framer_dma_pkg::DMA_IDLE;
            end
        endcase

        // Disable or channel reset abandons the transfer
        if (dma_reset || !run)
        begin
            next_st.dma_state = framer_dma_pkg::DMA_IDLE;
            next_st.req_n = 1'b1;
            next_st.pop = 1'b0;
        end
        if (dma_reset)
        begin
            next_st.flush = 1'b1;
        end
    end

    // ====================================================================
    // State register
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            st <= framer_dma_pkg::CTRL_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ====================================================================
    // Outputs
    assign data_out = st.dout;
    assign data_oe_n = st.oe_n;
    assign read_transfer_request_n = st.req_n;
    assign buf_pop = st.pop;
    assign buf_flush = st.flush;

endmodule

`default_nettype wire

// >>> verif/framer_rx_dma_properties.sv
// Port assertions for the framer receive DMA and interrupt control block
`timescale 1ns/1ns
`default_nettype none

module framer_rx_dma_checker
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Microprocessor bus
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [15:0] addr,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n,
    // DMA handshake
    input wire logic read_transfer_request_n,
    input wire logic read_transfer_grant_n,
    // Receive buffer
    input wire logic msg_ready,
    input wire logic [7:0] buf_data,
    input wire logic buf_last,
    input wire logic buf_pop,
    input wire logic buf_flush,
    // Interrupts
    input wire logic [framer_dma_pkg::IRQ_SOURCES-1:0] irq_events,
    input wire logic framer_irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // ==========
    // Steps of a byte transfer
    sequence s_strobe_seen;
        !$past(rd_n, 3) || !$past(wr_n, 3);
    endsequence

    sequence s_byte_out;
        !data_oe_n && data_out == $past(buf_data);
    endsequence

    // ==========
    // Properties
    a_no_partial_request: assert property ($fell(read_transfer_request_n) |-> $past(msg_ready))
        else $error("request raised without a complete message");
    a_pop_needs_request: assert property (buf_pop |-> !$past(read_transfer_request_n))
        else $error("byte taken without a pending request");
    a_pop_needs_grant: assert property (buf_pop |-> !$past(read_transfer_grant_n, 2))
        else $error("byte taken without a grant");
    a_byte_on_bus: assert property ($rose(buf_pop) |-> s_byte_out)
        else $error("popped byte not driven on the bus");
    a_pop_after_strobe: assert property (buf_pop |-> s_strobe_seen)
        else $error("byte taken without a strobe");
    a_oe_after_strobe: assert property ($fell(data_oe_n) |-> s_strobe_seen)
        else $error("bus driven without a strobe");
    a_last_ends_request: assert property (buf_pop && $past(buf_last) |-> read_transfer_request_n)
        else $error("request held after the last byte");
    a_pop_is_pulse: assert property (buf_pop |=> !buf_pop)
        else $error("one strobe took two bytes");
    a_flush_drops_request: assert property (buf_flush |-> read_transfer_request_n ##1 !buf_flush)
        else $error("channel reset left the request pending");
endmodule

bind framer_rx_dma_and_irq_control framer_rx_dma_checker i_checker (.core_clk, .rst_n, .cs_n, .rd_n, .wr_n,
    .addr, .data_in, .data_out, .data_oe_n, .read_transfer_request_n, .read_transfer_grant_n, .msg_ready,
    .buf_data, .buf_last, .buf_pop, .buf_flush, .irq_events, .framer_irq);

`default_nettype wire

// >>> verif/dma_controller_model.sv
// Behavioural external DMA controller that drains receive messages
`timescale 1ns/1ns
`default_nettype none

module dma_controller_model
(
    // Clock and bench controls
    input wire logic core_clk,
    input wire logic style,
    input wire logic hold,
    input wire logic [3:0] delay,
    // Device side
    input wire logic read_transfer_request_n,
    input wire logic [7:0] data_out,
    output logic read_transfer_grant_n,
    output logic dma_rd_n,
    output logic dma_wr_n,
    // Bytes taken, newest lowest
    output logic [63:0] got,
    output int count
);
    initial
    begin
        read_transfer_grant_n = 1'b1;
        dma_rd_n = 1'b1;
        dma_wr_n = 1'b1;
        got = 64'h0;
        count = 0;
    end

    always @(negedge core_clk)
    begin
        if (!read_transfer_request_n && !hold)
        begin
            got = 64'h0;
            count = 0;
            repeat (delay) @(negedge core_clk);
            read_transfer_grant_n = 1'b0;
            repeat (3) @(negedge core_clk);
            while (!read_transfer_request_n)
            begin
                // Style 1 sets direction a cycle ahead of the data strobe
                dma_rd_n = 1'b0;
                if (style)
                    @(negedge core_clk);
                dma_wr_n = !style;
                repeat (5) @(negedge core_clk);
                got = {got[55:0], data_out};
                count++;
                dma_wr_n = 1'b1;
                if (style)
                    @(negedge core_clk);
                dma_rd_n = 1'b1;
                repeat (5) @(negedge core_clk);
            end
            read_transfer_grant_n = 1'b1;
        end
    end
endmodule

`default_nettype wire

// >>> verif/framer_rx_dma_and_irq_control_bench.sv
// Self-checking bench for the framer receive DMA and interrupt control block
`timescale 1ns/1ns
`default_nettype none

module framer_rx_dma_and_irq_control_bench;
    logic core_clk, rst_n, cs_n, rd_n, wr_n, bus_rd_n, bus_wr_n, dma_rd_n, dma_wr_n, sty, hold;
    logic data_oe_n, read_transfer_request_n, read_transfer_grant_n, msg_ready, buf_last, buf_pop, buf_flush;
    logic framer_irq;
    logic [15:0] addr;
    logic [7:0] data_in, data_out, buf_data, rdata;
    logic [framer_dma_pkg::IRQ_SOURCES-1:0] irq_events;
    logic [3:0] delay;
    logic [31:0] msg;
    logic [63:0] got;
    int count, mlen, midx, flushes, fails, total_checks, cycles;

    assign rd_n = bus_rd_n & dma_rd_n;
    assign wr_n = bus_wr_n & dma_wr_n;
    assign msg_ready = midx < mlen;
    assign buf_last = midx == mlen - 1;
    assign buf_data = (midx < mlen) ? msg[31 - 8 * midx -: 8] : 8'h5A;

    framer_rx_dma_and_irq_control i_dut (.core_clk, .rst_n, .cs_n, .rd_n, .wr_n, .addr, .data_in, .data_out,
        .data_oe_n, .read_transfer_request_n, .read_transfer_grant_n, .msg_ready, .buf_data, .buf_last,
        .buf_pop, .buf_flush, .irq_events, .framer_irq);
    dma_controller_model i_dma (.core_clk, .style(sty), .hold, .delay, .read_transfer_request_n, .data_out,
        .read_transfer_grant_n, .dma_rd_n, .dma_wr_n, .got, .count);

    always #25 core_clk = ~core_clk;

    // ==========
    // Receive buffer and timeout
    always @(negedge core_clk)
    begin
        if (buf_pop === 1'b1)
            midx++;
        if (buf_flush === 1'b1)
        begin
            midx = mlen;
            flushes++;
        end
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            fails++;
            finish_test();
        end
    end

    // ==========
    // Tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp_v);
        total_checks++;
        if (seen !== exp_v)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp_v);
        end
    endtask

    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
        addr = a;
        data_in = d;
        cs_n = 1'b0;
        bus_rd_n = sty ? wr : 1'b1;
        repeat (3) @(negedge core_clk);
        if (sty || wr)
            bus_wr_n = 1'b0;
        else
            bus_rd_n = 1'b0;
        repeat (5) @(negedge core_clk);
        rdata = data_out;
        if (!wr)
            check({7'h00, data_oe_n}, 8'h00);
        bus_rd_n = 1'b1;
        bus_wr_n = 1'b1;
        cs_n = 1'b1;
        data_in = ~d;
        repeat (5) @(negedge core_clk);
        check({7'h00, data_oe_n}, 8'h01);
    endtask

    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        access(1'b1, a, d);
    endtask

    task automatic reg_read(input logic [15:0] a, input logic [7:0] exp_v);
        access(1'b0, a, 8'h00);
        check(rdata, exp_v);
    endtask

    task automatic load(input logic [31:0] bytes, input int n);
        msg = bytes;
        mlen = n;
        midx = 0;
    endtask

    task automatic wait_for(input bit grant, input logic lvl);
        for (int i = 0; i < 300 && (grant ? read_transfer_grant_n : read_transfer_request_n) !== lvl; i++)
            @(negedge core_clk);
        check({7'h00, grant ? read_transfer_grant_n : read_transfer_request_n}, {7'h00, lvl});
    endtask

    task automatic no_request;
        repeat (20) @(negedge core_clk);
        check({7'h00, read_transfer_request_n}, 8'h01);
    endtask

    task automatic dma_run(input logic [31:0] bytes, input int n);
        load(bytes, n);
        wait_for(1'b0, 1'b0);
        wait_for(1'b0, 1'b1);
        wait_for(1'b1, 1'b1);
        check(8'(count), 8'(n));
        for (int i = 0; i < n; i++)
            check(got[8 * (n - 1 - i) +: 8], bytes[31 - 8 * i -: 8]);
    endtask

    task automatic pulse(input logic [7:0] ev, input logic irq_exp);
        irq_events = ev;
        @(negedge core_clk);
        irq_events = 8'h00;
        repeat (3) @(negedge core_clk);
        check({7'h00, framer_irq}, {7'h00, irq_exp});
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==========
    // Main sequence
    initial
    begin
        {core_clk, rst_n, sty, hold, addr, data_in, irq_events, delay, msg} = '0;
        {cs_n, bus_rd_n, bus_wr_n} = 3'h7;
        {mlen, midx, flushes, fails, total_checks, cycles} = '0;
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        reg_read(framer_dma_pkg::DMA_CFG_ADDR, 8'h00);
        reg_read(framer_dma_pkg::IRQ_CTRL_ADDR, 8'h00);
        reg_write(framer_dma_pkg::DMA_CFG_ADDR, 8'h9F);
        reg_read(framer_dma_pkg::DMA_CFG_ADDR, 8'h87);
        check(8'(flushes), 8'h01);
        reg_read(16'h0120, 8'h00);
        reg_write(framer_dma_pkg::IRQ_CTRL_ADDR, 8'hFF);
        reg_read(framer_dma_pkg::IRQ_CTRL_ADDR, 8'h07);
        load(32'hDEADBEEF, 2);
        reg_write(framer_dma_pkg::DMA_CFG_ADDR, 8'h00);
        no_request();
        reg_write(framer_dma_pkg::DMA_CFG_ADDR, 8'h44);
        no_request();
        reg_write(framer_dma_pkg::DMA_CFG_ADDR, 8'h41);
        no_request();
        load(32'h0, 0);
        reg_write(framer_dma_pkg::DMA_CFG_ADDR, 8'h40);
        no_request();
        dma_run(32'h11223344, 3);
        delay = 4'h6;
        dma_run(32'hA5000000, 1);
        reg_write(framer_dma_pkg::DMA_CFG_ADDR, 8'h60);
        sty = 1'b1;
        dma_run(32'hC3E1F00F, 4);
        reg_read(framer_dma_pkg::DMA_CFG_ADDR, 8'h60);
        reg_write(framer_dma_pkg::DMA_CFG_ADDR, 8'h40);
        sty = 1'b0;
        hold = 1'b1;
        load(32'h01020304, 4);
        wait_for(1'b0, 1'b0);
        reg_write(framer_dma_pkg::DMA_CFG_ADDR, 8'hC0);
        check(8'(flushes), 8'h02);
        check({7'h00, read_transfer_request_n}, 8'h01);
        hold = 1'b0;
        reg_write(framer_dma_pkg::DMA_CFG_ADDR, 8'h00);
        reg_write(framer_dma_pkg::IRQ_CTRL_ADDR, 8'h01);
        reg_write(framer_dma_pkg::IRQ_ENABLE_ADDR, 8'h01);
        pulse(8'h01, 1'b1);
        reg_read(framer_dma_pkg::IRQ_STATUS_ADDR, 8'h01);
        reg_read(framer_dma_pkg::IRQ_STATUS_ADDR, 8'h00);
        reg_read(framer_dma_pkg::IRQ_ENABLE_ADDR, 8'h01);
        reg_write(framer_dma_pkg::IRQ_CTRL_ADDR, 8'h03);
        pulse(8'h01, 1'b1);
        reg_read(framer_dma_pkg::IRQ_STATUS_ADDR, 8'h01);
        reg_read(framer_dma_pkg::IRQ_ENABLE_ADDR, 8'h00);
        reg_write(framer_dma_pkg::IRQ_CTRL_ADDR, 8'h05);
        reg_write(framer_dma_pkg::IRQ_ENABLE_ADDR, 8'hFF);
        pulse(8'h02, 1'b1);
        reg_read(framer_dma_pkg::IRQ_STATUS_ADDR, 8'h02);
        reg_read(framer_dma_pkg::IRQ_STATUS_ADDR, 8'h02);
        reg_write(framer_dma_pkg::IRQ_STATUS_ADDR, 8'h02);
        reg_read(framer_dma_pkg::IRQ_STATUS_ADDR, 8'h00);
        reg_write(framer_dma_pkg::IRQ_CTRL_ADDR, 8'h04);
        pulse(8'h04, 1'b0);
        reg_read(framer_dma_pkg::IRQ_STATUS_ADDR, 8'h04);
        finish_test();
    end
endmodule

`default_nettype wire
